/* core/spn_if.sv */
// interface carrying the register strobes between the bus slave and the serial core
// assumes a single clock domain
interface spn_if;
    logic       buf_wr;
    logic [7:0] buf_wdata;
    logic       buf_rd;
    modport bus  (output buf_wr, output buf_wdata, output buf_rd);
    modport core (input buf_wr, input buf_wdata, input buf_rd);
endinterface

/* core/spn_pkg.sv */
// package for the serial port: register map, field positions, modes and timing
// assumes a 40 MHz system clock and an ahb-lite register bus
package spn_pkg;

    // register byte offsets
    localparam logic [7:0] SPN_CTRL_OFS = 8'h00;
    localparam logic [7:0] SPN_BUF_OFS  = 8'h04;
    localparam logic [7:0] SPN_STAT_OFS = 8'h08;

    // control register fields
    localparam int SPN_MODE_LSB  = 0;
    localparam int SPN_REN_BIT   = 2;
    localparam int SPN_MPC_BIT   = 3;
    localparam int SPN_TB8_BIT   = 4;
    localparam int SPN_RB8_BIT   = 5;
    localparam int SPN_TDONE_BIT = 6;
    localparam int SPN_RDONE_BIT = 7;
    localparam int SPN_SLOW_BIT  = 8;

    localparam logic [8:0] SPN_CTRL_RST = 9'h000;

    // oscillator cycles per serial state (one machine cycle here)
    localparam int          SPN_OSC_HZ      = 40000000;
    localparam logic [3:0]  SPN_CNT_LAST    = 4'hf;
    localparam logic [3:0]  SPN_VOTE_A      = 4'h7;
    localparam logic [3:0]  SPN_VOTE_B      = 4'h8;
    localparam logic [3:0]  SPN_VOTE_C      = 4'h9;
    localparam logic [8:0]  SPN_RX_ASYNC_INIT = 9'h1ff;
    localparam logic [7:0]  SPN_RX_SYNC_INIT  = 8'hfe;
    localparam logic [3:0]  SPN_SYNC_BITS   = 4'h8;

    typedef enum logic [1:0] {
        SPN_MODE_SHIFT = 2'b00,
        SPN_MODE_RSVD  = 2'b01,
        SPN_MODE_FIXED = 2'b10,
        SPN_MODE_TIMER = 2'b11
    } spn_mode_t;

endpackage

/* core/spn_rate.sv */
// bit-rate tick generator: gives one pulse per 1/16 bit time
// assumes timer overflow pulses are already on the system clock
module spn_rate
    import spn_pkg::*;
(
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // control
    input  wire logic [1:0] mode_in,
    input  wire logic       slow_in,
    input  wire logic       tmr_ovf_in,
    // tick out
    output logic            tick_out
);
    logic tog_ff;

    // fixed mode divides by two once more when slow is set (1/16 or 1/32 of osc)
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tog_ff <= 1'b0;
        end else begin
            tog_ff <= ~tog_ff;
        end
    end

    always_comb begin
        if (mode_in == SPN_MODE_TIMER) begin
            tick_out = tmr_ovf_in;
        end else if (slow_in) begin
            tick_out = tog_ff;
        end else begin
            tick_out = 1'b1;
        end
    end
endmodule

/* core/spn_top.sv */
// serial port with shift-register mode and nine-bit asynchronous modes
// assumes rxd pin asynchronous; timer overflow pulse on clk_in; one ahb-lite master
// ------------------------------------------------------------
// Summary of operation
// - shift mode: eight bits lsb first, clock osc/2
// - buffer write loads marker, send after cycle
// - send drives data and clock, shift right
// - marker left of msb: last shift, done
// - rx starts when enabled and flag clear
// - shift left on falling, rising-edge sample
// - zero marker leftmost: last shift, store
// - frame: start, eight data, ninth, stop
// - send tx ninth bit, store rx ninth
// - fixed rate osc/16 or /32, timer rate
// - start send after next counter rollover
// - start bit, data, stop inserted on shift
// - ninth out, stop left: done flag set
// - sample x16, falling edge resets counter
// - vote two of three mid samples
// - false start bit abandons the frame
// - nine-bit receive register, final shift
// - store only if flag clear and address
// - resume hunting one bit time later
// - stop bit value ignored
// - shift mode ignores multiprocessor compare
// ------------------------------------------------------------
//
// The placing of the registers and the AHB-Lite slave port are this design's own decisions.
module spn_top
    import spn_pkg::*;
(
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_in,
    // ahb-lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic [31:0]      hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // timer overflow pulse
    input  wire logic        tmr_ovf_in,
    // serial pins: data line is two-way, clock line output
    input  wire logic        rxd_in,
    output logic             rxd_out,
    output logic             rxd_oe_out,
    output logic             txd_out
);
    spn_if rif ();

    // ------------------------------------------------------------
    // bus slave
    // ------------------------------------------------------------
    logic        ph_ff;
    logic        ph_wr_ff;
    logic [7:0]  ph_adr_ff;
    logic [8:0]  ctrl_ff;
    logic [7:0]  rbuf_ff;
    logic [31:0] hrdata_ff;
    logic        ctl_wr;
    logic        set_tdone;
    logic        set_rdone;
    logic        rb8_val;
    logic        send_ff;
    logic        rx_busy_ff;
    logic [8:0]  nxt_ctrl;

    // bit-order swap: both receive registers fill from the right, lsb first
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7 - i];
        end
        return r;
    endfunction

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ph_ff     <= 1'b0;
            ph_wr_ff  <= 1'b0;
            ph_adr_ff <= 8'h00;
        end else if (hready_in) begin
            ph_ff     <= hsel_in & htrans_in[1];
            ph_wr_ff  <= hwrite_in;
            ph_adr_ff <= haddr_in[7:0];
        end
    end

    assign ctl_wr         = ph_ff & ph_wr_ff & (ph_adr_ff == SPN_CTRL_OFS);
    assign rif.buf_wr     = ph_ff & ph_wr_ff & (ph_adr_ff == SPN_BUF_OFS);
    assign rif.buf_wdata  = hwdata_in[7:0];
    assign rif.buf_rd     = ph_ff & ~ph_wr_ff & (ph_adr_ff == SPN_BUF_OFS);
    assign hreadyout_out  = 1'b1;
    assign hresp_out      = 1'b0;

    // read data registered at the address phase; unmapped reads return zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hrdata_ff <= 32'h0;
        end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
            unique case (haddr_in[7:0])
                SPN_CTRL_OFS: hrdata_ff <= {23'h0, nxt_ctrl};
                SPN_BUF_OFS:  hrdata_ff <= {24'h0, rbuf_ff};
                SPN_STAT_OFS: hrdata_ff <= {30'h0, rx_busy_ff, send_ff};
                default:      hrdata_ff <= 32'h0;
            endcase
        end
    end
    assign hrdata_out = hrdata_ff;

    // control: hardware set wins over software clear of the done flags;
    // reads see the next value so a read right after a write is not stale
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (ctl_wr) begin
            nxt_ctrl = hwdata_in[8:0];
        end
        if (set_tdone) begin
            nxt_ctrl[SPN_TDONE_BIT] = 1'b1;
        end
        if (set_rdone) begin
            nxt_ctrl[SPN_RDONE_BIT] = 1'b1;
            nxt_ctrl[SPN_RB8_BIT]   = rb8_val;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_ff <= SPN_CTRL_RST;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    wire [1:0] mode  = ctrl_ff[SPN_MODE_LSB +: 2];
    wire       sync  = (mode == SPN_MODE_SHIFT);
    wire       ren   = ctrl_ff[SPN_REN_BIT];
    wire       rdone = ctrl_ff[SPN_RDONE_BIT];
    wire       mpc   = ctrl_ff[SPN_MPC_BIT] & ~sync;

    // ------------------------------------------------------------
    // rate and pin synchroniser
    // ------------------------------------------------------------
    logic tick;
    logic rxd_s1_ff;
    logic rxd_s2_ff;
    logic rxd_d_ff;

    spn_rate u_rate (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .mode_in    (mode),
        .slow_in    (ctrl_ff[SPN_SLOW_BIT]),
        .tmr_ovf_in (tmr_ovf_in),
        .tick_out   (tick)
    );

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rxd_s1_ff <= 1'b1;
            rxd_s2_ff <= 1'b1;
            rxd_d_ff  <= 1'b1;
        end else begin
            rxd_s1_ff <= rxd_in;
            rxd_s2_ff <= rxd_s1_ff;
            rxd_d_ff  <= rxd_s2_ff;
        end
    end

    // ------------------------------------------------------------
    // transmitter
    // ------------------------------------------------------------
    logic       data_ff;
    logic       pend_ff;
    logic [8:0] tsr_ff;
    logic [3:0] tcnt_ff;
    logic       sclk_ff;
    logic       txo_ff;
    logic       first_ff;
    wire        troll = tick & (tcnt_ff == SPN_CNT_LAST);

    // tx divide-by-16 counter free runs so bit times align to it
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tcnt_ff <= 4'h0;
        end else if (tick) begin
            tcnt_ff <= tcnt_ff + 4'h1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            send_ff   <= 1'b0;
            data_ff   <= 1'b0;
            pend_ff   <= 1'b0;
            first_ff  <= 1'b0;
            tsr_ff    <= 9'h000;
            sclk_ff   <= 1'b1;
            set_tdone <= 1'b0;
        end else begin
            set_tdone <= 1'b0;
            if (rif.buf_wr) begin
                // ninth position: marker in shift mode, tx ninth bit otherwise
                tsr_ff  <= {sync | ctrl_ff[SPN_TB8_BIT], rif.buf_wdata};
                pend_ff <= 1'b1;
            end else if (sync) begin
                if (pend_ff) begin
                    pend_ff  <= 1'b0;
                    send_ff  <= 1'b1;
                    sclk_ff  <= 1'b0;
                    first_ff <= 1'b1;
                end else if (send_ff) begin
                    sclk_ff <= ~sclk_ff;
                    // shift on the pin's falling edge; the first fall comes before bit 0 is taken
                    if (!sclk_ff) begin
                        if (first_ff) begin
                            first_ff <= 1'b0;
                        end else begin
                            tsr_ff <= {1'b0, tsr_ff[8:1]};
                            if (tsr_ff[8:1] == 8'h01) begin
                                send_ff   <= 1'b0;
                                set_tdone <= 1'b1;
                            end
                        end
                    end
                end else if (rx_busy_ff) begin
                    sclk_ff <= ~sclk_ff;
                end else begin
                    sclk_ff <= 1'b1;
                end
            end else begin
                if (pend_ff && troll) begin
                    pend_ff  <= 1'b0;
                    send_ff  <= 1'b1;
                    data_ff  <= 1'b0;
                    first_ff <= 1'b1;
                end else if (send_ff && troll) begin
                    if (!data_ff) begin
                        data_ff <= 1'b1;
                    end else if (tsr_ff[8:1] == 8'h01 && !first_ff) begin
                        send_ff   <= 1'b0;
                        data_ff   <= 1'b0;
                        set_tdone <= 1'b1;
                        tsr_ff    <= 9'h000;
                    end else begin
                        tsr_ff   <= {first_ff, tsr_ff[8:1]};
                        first_ff <= 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // receiver
    // ------------------------------------------------------------
    logic       rx_arm_ff;
    logic       rx_tail_ff;
    logic [8:0] rsr_ff;
    logic [3:0] rcnt_ff;
    logic [2:0] vote_ff;
    logic       rstart_ff;
    logic       rsamp_ff;
    wire        voted = (vote_ff[0] & vote_ff[1]) | (vote_ff[1] & vote_ff[2])
                      | (vote_ff[0] & vote_ff[2]);

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rx_busy_ff <= 1'b0;
            rx_arm_ff  <= 1'b0;
            rx_tail_ff <= 1'b0;
            rstart_ff  <= 1'b0;
            rsamp_ff   <= 1'b0;
            rsr_ff     <= 9'h000;
            rcnt_ff    <= 4'h0;
            vote_ff    <= 3'h0;
            rbuf_ff    <= 8'h00;
            set_rdone  <= 1'b0;
            rb8_val    <= 1'b0;
        end else begin
            set_rdone <= 1'b0;
            if (sync) begin
                if (!rx_busy_ff && !rx_arm_ff && ren && !rdone && !send_ff && !pend_ff
                    && !set_rdone) begin
                    rx_arm_ff <= 1'b1;
                end else if (rx_arm_ff) begin
                    rx_arm_ff  <= 1'b0;
                    rsr_ff     <= {1'b0, SPN_RX_SYNC_INIT};
                    rx_busy_ff <= 1'b1;
                    // synchroniser lag: two falls pass before bit 0 is sampled
                    rstart_ff  <= 1'b1;
                    rx_tail_ff <= 1'b1;
                end else if (rx_busy_ff) begin
                    if (sclk_ff) begin
                        rsamp_ff <= rxd_s2_ff;
                    end else if (rstart_ff) begin
                        rstart_ff <= 1'b0;
                    end else if (rx_tail_ff) begin
                        rx_tail_ff <= 1'b0;
                    end else begin
                        rsr_ff <= {1'b0, rsr_ff[6:0], rsamp_ff};
                        if (!rsr_ff[7]) begin
                            rbuf_ff    <= rev8({rsr_ff[6:0], rsamp_ff});
                            rx_busy_ff <= 1'b0;
                            set_rdone  <= 1'b1;
                            rb8_val    <= ctrl_ff[SPN_RB8_BIT];
                        end
                    end
                end
            end else if (!rx_busy_ff) begin
                if (rxd_d_ff && !rxd_s2_ff) begin
                    rx_busy_ff <= 1'b1;
                    rstart_ff  <= 1'b1;
                    rcnt_ff    <= 4'h0;
                    rsr_ff     <= SPN_RX_ASYNC_INIT;
                end
            end else if (tick) begin
                rcnt_ff <= rcnt_ff + 4'h1;
                if (rcnt_ff == SPN_VOTE_A) vote_ff[0] <= rxd_s2_ff;
                if (rcnt_ff == SPN_VOTE_B) vote_ff[1] <= rxd_s2_ff;
                if (rcnt_ff == SPN_VOTE_C) vote_ff[2] <= rxd_s2_ff;
                if (rcnt_ff == SPN_CNT_LAST) begin
                    if (rx_tail_ff) begin
                        rx_tail_ff <= 1'b0;
                        rx_busy_ff <= 1'b0;
                    end else if (rstart_ff && voted) begin
                        rx_busy_ff <= 1'b0;
                        rstart_ff  <= 1'b0;
                    end else if (!rsr_ff[8]) begin
                        // start bit leftmost: no shift here, this vote is the ninth bit
                        rx_tail_ff <= 1'b1;
                        if (!rdone && (!mpc || voted)) begin
                            rbuf_ff   <= rev8(rsr_ff[7:0]);
                            rb8_val   <= voted;
                            set_rdone <= 1'b1;
                        end
                    end else begin
                        rstart_ff <= 1'b0;
                        rsr_ff    <= {rsr_ff[7:0], voted};
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // pin drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            txo_ff <= 1'b1;
        end else if (sync) begin
            txo_ff <= (send_ff | rx_busy_ff) ? sclk_ff : 1'b1;
        end else if (send_ff) begin
            txo_ff <= data_ff ? tsr_ff[0] : 1'b0;
        end else begin
            txo_ff <= 1'b1;
        end
    end

    assign txd_out    = txo_ff;
    assign rxd_out    = tsr_ff[0];
    assign rxd_oe_out = sync & send_ff;
endmodule

/* tb/spn_peer.sv */
// far-side peer: shift-register device for mode 0, remote nine-bit serial port
// assumes the data line idles high through its pull-up when nobody drives it
module spn_peer
(
    // clock and line taps
    input  wire logic clk_in,
    input  wire logic sclk_in,
    input  wire logic dat_in,
    input  wire logic dat_oe_in,
    // far-side drive of the data line
    output logic      drv_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       m0_en = 1'b0;
    logic [7:0] m0_byte = 8'h00;
    logic       m0_bits[$];
    initial drv_out = 1'b1;
    // next bit after each falling clock; ones fill in so the line ends released high
    always @(negedge sclk_in) begin
        if (m0_en && !dat_oe_in) begin
            drv_out <= m0_byte[0];
            m0_byte = {1'b1, m0_byte[7:1]};
        end
    end
    always @(posedge sclk_in) if (dat_oe_in) m0_bits.push_back(dat_in);
    task automatic send(input logic [8:0] d9, input logic stop, input int bc);
        logic [10:0] f;
        f = {stop, d9, 1'b0};
        for (int i = 0; i < 11; i++) begin
            drv_out <= f[i];
            repeat (bc) @(posedge clk_in);
        end
        drv_out <= 1'b1;
        repeat (bc) @(posedge clk_in);
    endtask
    task automatic glitch(input int n, input int bc);
        drv_out <= 1'b0;
        repeat (n) @(posedge clk_in);
        drv_out <= 1'b1;
        repeat (2 * bc) @(posedge clk_in);
    endtask
    task automatic grab(input int bc, output logic [10:0] f);
        @(negedge sclk_in);
        repeat (bc / 2) @(posedge clk_in);
        for (int i = 0; i < 11; i++) begin
            f[i] = sclk_in;
            repeat (bc) @(posedge clk_in);
        end
    endtask
endmodule

/* tb/spn_sva.sv */
// checker for the serial port top: bus answer, reset levels and line timing
// assumes it is bound to spn_top and sees only that module's ports
module spn_chk
    import spn_pkg::*;
(
    // clock, reset and bus
    input wire logic        clk_in,
    input wire logic        rst_in,
    input wire logic        hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0]  htrans_in,
    input wire logic        hwrite_in,
    input wire logic [31:0] hwdata_in,
    input wire logic        hready_in,
    input wire logic [31:0] hrdata_out,
    input wire logic        hreadyout_out,
    input wire logic        hresp_out,
    // serial pins
    input wire logic        rxd_out,
    input wire logic        rxd_oe_out,
    input wire logic        txd_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    logic       wr_ctl_ff;
    logic [1:0] mode_ff;
    logic       slow_ff;
    logic       m2_fast;
    // shadow of the mode field, updated in the same data phase as the design
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            wr_ctl_ff <= 1'b0;
            mode_ff   <= 2'b00;
            slow_ff   <= 1'b0;
        end else begin
            wr_ctl_ff <= hsel_in && hready_in && htrans_in[1] && hwrite_in
                         && haddr_in == 32'(SPN_CTRL_OFS);
            if (wr_ctl_ff) begin
                mode_ff <= hwdata_in[1:0];
                slow_ff <= hwdata_in[SPN_SLOW_BIT];
            end
        end
    end
    assign m2_fast = (mode_ff == SPN_MODE_FIXED) && !slow_ff;
    sequence s_low_bit;
        (!txd_out)[*8] ##1 (!txd_out)[*8];
    endsequence
    sequence s_high_bit;
        txd_out[*8] ##1 txd_out[*8];
    endsequence
    chk_ready_high: assert property (hreadyout_out) else $error("hreadyout low");
    chk_resp_okay: assert property (!hresp_out) else $error("error response");
    chk_reset_idle: assert property ($fell(rst_in) |-> txd_out && !rxd_oe_out
        && hrdata_out == 32'h0) else $error("outputs not idle after reset");
    chk_unmapped_zero: assert property (hsel_in && hready_in && htrans_in[1] && !hwrite_in
        && haddr_in == 32'h0000_000c |=> hrdata_out == 32'h0) else $error("unmapped read");
    chk_oe_shift_only: assert property (rxd_oe_out |-> mode_ff == SPN_MODE_SHIFT)
        else $error("data line driven outside shift mode");
    chk_sclk_toggles: assert property (rxd_oe_out && $past(rxd_oe_out) |-> $changed(txd_out))
        else $error("shift clock not at half rate");
    chk_data_on_low: assert property (rxd_oe_out && $past(rxd_oe_out)
        && $changed(rxd_out) |-> !txd_out) else $error("data changed while clock high");
    chk_low_bit_len: assert property ($fell(txd_out) && m2_fast |-> s_low_bit)
        else $error("low bit shorter than sixteen cycles");
    chk_high_bit_len: assert property ($rose(txd_out) && m2_fast |-> s_high_bit)
        else $error("high bit shorter than sixteen cycles");
endmodule

bind spn_top spn_chk chk_u (
    .clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel_in), .haddr_in(haddr_in),
    .htrans_in(htrans_in), .hwrite_in(hwrite_in), .hwdata_in(hwdata_in),
    .hready_in(hready_in), .hrdata_out(hrdata_out), .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out), .rxd_out(rxd_out), .rxd_oe_out(rxd_oe_out), .txd_out(txd_out)
);

/* tb/spn_top_tb.sv */
// self-checking bench for the serial port: ahb-lite tasks, peer model, expected values
// assumes spn_peer on the far side and the checker bound to spn_top
module spn_top_tb
    import spn_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BIT_CLK [3] = '{16, 32, 128};
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        tmr_ovf = 1'b0;
    logic [1:0]  htrans = 2'b00;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic        hreadyout, hresp, rxd_out, rxd_oe, txd, peer_drv;
    wire logic   rxd_line;
    logic [7:0]  exp_q[$];
    int          cyc = 0;
    int          failures = 0;
    int          checked = 0;
    initial begin
        forever #12.5 clk_in = ~clk_in;
    end
    // timer overflow every 8 cycles gives a 200 ns tick for mode 3
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        tmr_ovf <= (cyc % 8 == 7);
    end
    assign rxd_line = rxd_oe ? rxd_out : peer_drv;
    spn_top dut_u (
        .clk_in(clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010), .hwdata_in(hwdata),
        .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout),
        .hresp_out(hresp), .tmr_ovf_in(tmr_ovf), .rxd_in(rxd_line), .rxd_out(rxd_out),
        .rxd_oe_out(rxd_oe), .txd_out(txd)
    );
    spn_peer peer_u (
        .clk_in(clk_in), .sclk_in(txd), .dat_in(rxd_line), .dat_oe_in(rxd_oe),
        .drv_out(peer_drv)
    );
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk_in); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_in); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q & m, e);
    endtask
    // polls under a bound; the caller's compare reports a flag that never came
    task automatic wait_bit(input int b);
        logic [31:0] q;
        int          n;
        n = 0;
        do begin
            bus(1'b0, 32'(SPN_CTRL_OFS), 32'h0, q);
            n++;
        end while (q[b] !== 1'b1 && n < 5000);
    endtask
    function automatic logic [31:0] ctl(input logic [1:0] m, input logic ren,
                                        input logic mpc, input logic tb8, input logic slow);
        ctl = 32'(m) | (32'(ren) << SPN_REN_BIT) | (32'(mpc) << SPN_MPC_BIT)
              | (32'(tb8) << SPN_TB8_BIT) | (32'(slow) << SPN_SLOW_BIT);
    endfunction
    task automatic report_and_stop();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_in);
        failures++;
        report_and_stop();
    end
    initial begin
        logic [7:0]  b;
        logic [8:0]  d9;
        logic [10:0] f;
        logic [1:0]  m;
        void'($urandom(32'h82a7));
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        rd_chk(32'(SPN_CTRL_OFS), 32'h1ff, 32'(SPN_CTRL_RST));
        wr(32'h0000_000c, 32'hffff_ffff);
        rd_chk(32'h0000_000c, 32'hffff_ffff, 32'h0);
        rd_chk(32'(SPN_STAT_OFS), 32'h3, 32'h0);
        b = 8'($urandom);
        exp_q.push_back(b);
        wr(32'(SPN_BUF_OFS), {24'h0, b});
        wait_bit(SPN_TDONE_BIT);
        chk(32'(peer_u.m0_bits.size()), 32'd8);
        for (int i = 0; i < 8; i++) chk(32'(peer_u.m0_bits[i]), 32'(b[i]));
        rd_chk(32'(SPN_STAT_OFS), 32'h3, 32'h0);
        wr(32'(SPN_CTRL_OFS), 32'h0);
        rd_chk(32'(SPN_CTRL_OFS), 32'hc0, 32'h0);
        b = 8'($urandom);
        peer_u.m0_byte = b;
        peer_u.m0_en = 1'b1;
        wr(32'(SPN_CTRL_OFS), ctl(2'b00, 1'b1, 1'b1, 1'b0, 1'b0));
        wait_bit(SPN_RDONE_BIT);
        rd_chk(32'(SPN_BUF_OFS), 32'hff, {24'h0, b});
        wr(32'(SPN_CTRL_OFS), 32'h0);
        peer_u.m0_en = 1'b0;
        for (int i = 0; i < 3; i++) begin
            m = (i == 2) ? 2'b11 : 2'b10;
            d9 = 9'($urandom);
            exp_q.push_back(d9[7:0]);
            wr(32'(SPN_CTRL_OFS), ctl(m, 1'b0, 1'b0, d9[8], i == 1));
            fork
                peer_u.grab(BIT_CLK[i], f);
                wr(32'(SPN_BUF_OFS), {24'h0, d9[7:0]});
            join
            chk({21'h0, f}, {21'h0, 1'b1, d9[8], exp_q.pop_back(), 1'b0});
            wait_bit(SPN_TDONE_BIT);
            rd_chk(32'(SPN_CTRL_OFS), 32'h40, 32'h40);
            wr(32'(SPN_CTRL_OFS), ctl(m, 1'b1, 1'b1, 1'b0, i == 1));
            peer_u.glitch(3 * BIT_CLK[i] / 16, BIT_CLK[i]);
            peer_u.send({1'b0, 8'($urandom)}, 1'b1, BIT_CLK[i]);
            rd_chk(32'(SPN_CTRL_OFS), 32'h80, 32'h0);
            wr(32'(SPN_CTRL_OFS), ctl(m, 1'b1, 1'b0, 1'b0, i == 1));
            d9 = 9'($urandom);
            peer_u.send(d9, 1'b0, BIT_CLK[i]);
            wait_bit(SPN_RDONE_BIT);
            rd_chk(32'(SPN_CTRL_OFS), 32'ha0, {24'h0, 2'b10, d9[8], 5'h0});
            peer_u.send(~d9, 1'b1, BIT_CLK[i]);
            rd_chk(32'(SPN_BUF_OFS), 32'hff, {24'h0, d9[7:0]});
            wr(32'(SPN_CTRL_OFS), 32'h0);
        end
        chk(32'(exp_q.size()), 32'd1);
        report_and_stop();
    end
endmodule
